// ---- dv/tb_top.sv ----
// self-checking bench for the ahb-lite i/o error status words
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import io_err_pkg::*;
   ////////////////////////////////////////////////////////////////////////
   // bench signals
   logic        hclk;          // 40 MHz bus clock
   logic        hresetn;       // active-low reset
   logic        hsel;          // slave select
   logic [31:0] haddr;         // byte address
   logic [1:0]  htrans;        // transfer kind
   logic        hwrite;        // write strobe
   logic [2:0]  hsize;         // always a word
   logic [31:0] hwdata;        // write data, ignored by the slave
   wire  logic  hready;        // bus ready, fed from the one slave
   logic        hreadyout;     // slave ready
   logic        hresp;         // slave response
   logic [31:0] hrdata;        // read data
   cfg_check_s  cfg;           // configuration check inputs
   fault_evt_s  evt;           // fault event strobes
   int          err_count;     // mismatches seen
   int          checks_done;   // comparisons made
   logic [31:0] dummy;         // read data of writes, unused
   assign hready = hreadyout;
   ////////////////////////////////////////////////////////////////////////
   // design under test, default limits
   io_error_status_words DUT (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .cfg(cfg), .evt(evt)
   );
   // free-running clock, 25 ns period
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   ////////////////////////////////////////////////////////////////////////
   // closing report, the only place the run ends
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // wait for hready at a rising edge; a hang counts as a mismatch
   task automatic wait_ready;
      int n;
      for (n = 0; n < 64; n++) begin
         @(posedge hclk);
         if (hready === 1'b1) break;
      end
      if (n == 64) begin
         err_count++;
         $display("[ERR] %0t hready never came", $time);
         results();
      end
   endtask
   // one single ahb-lite word transfer, address then data phase
   task automatic ahb_xfer(input logic [31:0] a, input logic wr,
                           input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      hsize  <= 3'h2;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;       // taken at the edge that ends the data phase
      checks_done++;
      if (hresp !== HRESP_OKAY) begin
         err_count++;
         $display("[ERR] %0t response not okay", $time);
      end
   endtask
   // read a word and compare against the expected 16-bit value
   task automatic chk(input logic [4:0] off, input logic [15:0] exp);
      logic [31:0] d;
      ahb_xfer({27'h0, off}, 1'b0, 32'h0000_0000, d);
      checks_done++;
      if (d !== {16'h0000, exp}) begin
         err_count++;
         $display("[ERR] %0t at %h got %h want %h", $time, off, d, exp);
      end
   endtask
   // one-cycle fault event; strobes drop again at the next edge
   task automatic ev_fire(input fault_evt_s e);
      @(posedge hclk);
      evt <= e;
      @(posedge hclk);
      evt <= '0;
   endtask
   // one-cycle size check with its three qualifying counts
   task automatic cfg_fire(input logic [12:0] pts, input logic [12:0] irq,
                           input logic [12:0] rk);
      @(posedge hclk);
      cfg.cfg_stb    <= 1'b1;
      cfg.io_points  <= pts;
      cfg.irq_inputs <= irq;
      cfg.racks      <= rk;
      @(posedge hclk);
      cfg.cfg_stb    <= 1'b0;
   endtask
   // short mid-run reset, the only way sticky flags clear
   task automatic do_reset;
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      cfg = '0;
      evt = '0;
      err_count = 0;
      checks_done = 0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      // every word clear after reset, the address past the end reads zero
      for (int i = 0; i < 8; i++) chk(5'(i * 4), 16'h0000);
      // five motion modules is still legal, six is not
      cfg.mm_count <= 4'h5;
      chk(OFF_IO_FLAGS, 16'h0000);
      cfg.mm_count <= 4'h6;
      chk(OFF_IO_FLAGS, 16'h0400);
      cfg.mm_count <= 4'h0;
      ev_fire('{model_mismatch: 1'b1, default: '0});
      chk(OFF_IO_FLAGS, 16'h0C00);
      // processor unit duplicates at both ends of the unit range
      ev_fire('{cpu_dup_stb: 1'b1, cpu_dup_unit: 4'h0, default: '0});
      chk(OFF_IO_FLAGS, 16'h2C00);
      ev_fire('{cpu_dup_stb: 1'b1, cpu_dup_unit: 4'hF, default: '0});
      chk(OFF_DUP_MAP, 16'h8001);
      // software writes of all ones must leave every word alone
      for (int i = 0; i < 7; i++) ahb_xfer(32'(i * 4), 1'b1, 32'hFFFF_FFFF,
                                           dummy);
      chk(OFF_IO_FLAGS, 16'h2C00);
      chk(OFF_DUP_MAP, 16'h8001);
      chk(OFF_EXCESS, 16'h0000);
      do_reset();
      chk(OFF_IO_FLAGS, 16'h0000);
      // special unit ten is legal, nine is not, shared numbers are not
      ev_fire('{sio_stb: 1'b1, sio_unit: 7'h0A, default: '0});
      chk(OFF_IO_FLAGS, 16'h0000);
      ev_fire('{sio_stb: 1'b1, sio_unit: SIO_LOW_LAST, default: '0});
      chk(OFF_IO_FLAGS, 16'h2000);
      do_reset();
      ev_fire('{sio_stb: 1'b1, sio_dup: 1'b1, sio_unit: 7'h28,
                default: '0});
      chk(OFF_IO_FLAGS, 16'h2000);
      do_reset();
      ev_fire('{basic_overlap: 1'b1, default: '0});
      chk(OFF_IO_FLAGS, 16'h2000);
      // size checks: each cause, priority, and limits that are not passed
      cfg_fire(13'd641, 13'd0, 13'd0);
      chk(OFF_EXCESS, {CAUSE_IO_POINTS, 13'd641});
      cfg_fire(13'd640, 13'd33, 13'd0);
      chk(OFF_EXCESS, {CAUSE_IRQ, 13'd33});
      cfg_fire(13'd0, 13'd32, 13'd2);
      chk(OFF_EXCESS, {CAUSE_RACKS, 13'd2});
      cfg_fire(13'd640, 13'd32, 13'd1);
      chk(OFF_EXCESS, {CAUSE_RACKS, 13'd2});
      cfg_fire(13'h1FFF, 13'd40, 13'd3);
      chk(OFF_EXCESS, {CAUSE_IO_POINTS, 13'h1FFF});
      // bus error location, every kind of report
      ev_fire('{bus_err_stb: 1'b1, bus_err_kind: BUS_LOC_KNOWN,
                bus_slot: 8'h09, bus_rack: 8'h01, default: '0});
      chk(OFF_BUS_LOC, 16'h0109);
      ev_fire('{bus_err_stb: 1'b1, bus_err_kind: BUS_NO_COVER,
                bus_slot: 8'h03, default: '0});
      chk(OFF_BUS_LOC, {LOC_NO_COVER, LOC_NO_COVER});
      ev_fire('{bus_err_stb: 1'b1, bus_err_kind: BUS_LOC_UNSURE,
                default: '0});
      chk(OFF_BUS_LOC, {LOC_UNKNOWN, LOC_UNKNOWN});
      ev_fire('{bus_err_stb: 1'b1, bus_err_kind: BUS_LOC_KNOWN,
                bus_slot: 8'h00, bus_rack: 8'h00, default: '0});
      chk(OFF_BUS_LOC, 16'h0000);
      ev_fire('{bus_err_stb: 1'b1, bus_err_kind: bus_err_kind_e'(2'h3),
                default: '0});
      chk(OFF_BUS_LOC, {LOC_UNKNOWN, LOC_UNKNOWN});
      // memory errors: general bit alone, then table, then settings
      do_reset();
      ev_fire('{mem_err_stb: 1'b1, default: '0});
      chk(OFF_IO_FLAGS, 16'h8000);
      chk(OFF_MEM_DETAIL, 16'h0000);
      ev_fire('{mem_err_stb: 1'b1, mem_in_table: 1'b1, default: '0});
      chk(OFF_MEM_DETAIL, 16'h0001);
      ev_fire('{mem_err_stb: 1'b1, mem_in_settings: 1'b1, default: '0});
      chk(OFF_MEM_DETAIL, 16'h0003);
      chk(OFF_IO_FLAGS, 16'h8000);
      // exchange fault, unit mismatch, then a fault inside the unit
      ev_fire('{xchg_err_stb: 1'b1, err_unit: 4'h3, default: '0});
      chk(OFF_UNIT_FLAGS, 16'h0080);
      chk(OFF_ERR_MAP, 16'h0008);
      ev_fire('{unit_mismatch: 1'b1, default: '0});
      chk(OFF_UNIT_FLAGS, 16'h0088);
      do_reset();
      ev_fire('{unit_fault_stb: 1'b1, err_unit: 4'hC, default: '0});
      chk(OFF_UNIT_FLAGS, 16'h0080);
      chk(OFF_ERR_MAP, 16'h1000);
      results();
   end
endmodule
`default_nettype wire

// ---- rtl/io_err_pkg.sv ----
// shared constants and carrier types for the i/o error status words
`default_nettype none
package io_err_pkg;
   ////////////////////////////////////////////////////////////////////////
   // register byte addresses, one aligned word each
   localparam int          ADDR_W           = 5;
   localparam logic [4:0]  OFF_IO_FLAGS     = 5'h00;
   localparam logic [4:0]  OFF_UNIT_FLAGS   = 5'h04;
   localparam logic [4:0]  OFF_MEM_DETAIL   = 5'h08;
   localparam logic [4:0]  OFF_BUS_LOC      = 5'h0C;
   localparam logic [4:0]  OFF_EXCESS       = 5'h10;
   localparam logic [4:0]  OFF_DUP_MAP      = 5'h14;
   localparam logic [4:0]  OFF_ERR_MAP      = 5'h18;
   ////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int          BIT_IO_SETTING   = 10;
   localparam int          BIT_MODEL_MISM   = 11;
   localparam int          BIT_DUPLICATE    = 13;
   localparam int          BIT_MEMORY       = 15;
   localparam int          BIT_UNIT_SETTING = 3;
   localparam int          BIT_UNIT_ERROR   = 7;
   localparam int          BIT_MEM_TABLE    = 0;
   localparam int          BIT_MEM_SETTINGS = 1;
   localparam int          DETAIL_W         = 13;
   localparam int          CAUSE_W          = 3;
   ////////////////////////////////////////////////////////////////////////
   // reset values and codes
   localparam logic [15:0] WORD_RESET       = 16'h0000;
   localparam logic [2:0]  CAUSE_IO_POINTS  = 3'h1;
   localparam logic [2:0]  CAUSE_IRQ        = 3'h2;
   localparam logic [2:0]  CAUSE_RACKS      = 3'h3;
   localparam logic [7:0]  LOC_NO_COVER     = 8'h0E;
   localparam logic [7:0]  LOC_UNKNOWN      = 8'h0F;
   localparam logic [6:0]  SIO_LOW_LAST     = 7'h09;
   localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
   localparam logic        HRESP_OKAY       = 1'b0;
   ////////////////////////////////////////////////////////////////////////
   // kind of an i/o bus error report
   typedef enum logic [1:0] {
      BUS_LOC_KNOWN  = 2'h0,
      BUS_NO_COVER   = 2'h1,
      BUS_LOC_UNSURE = 2'h2
   } bus_err_kind_e;
   // configuration check presented by the detection logic
   typedef struct packed {
      logic [3:0]          mm_count;      // attached motion modules
      logic                cfg_stb;       // size check pulse
      logic [12:0]         io_points;     // total points, no slave racks
      logic [12:0]         irq_inputs;    // configured interrupt inputs
      logic [12:0]         racks;         // expansion racks
   } cfg_check_s;
   // fault events presented by the detection logic, one-cycle strobes
   typedef struct packed {
      logic                model_mismatch;
      logic                cpu_dup_stb;
      logic [3:0]          cpu_dup_unit;
      logic                sio_stb;
      logic                sio_dup;
      logic [6:0]          sio_unit;
      logic                basic_overlap;
      logic                bus_err_stb;
      logic [1:0]          bus_err_kind;  // a bus_err_kind_e code
      logic [7:0]          bus_slot;
      logic [7:0]          bus_rack;
      logic                mem_err_stb;
      logic                mem_in_table;
      logic                mem_in_settings;
      logic                xchg_err_stb;
      logic                unit_fault_stb;
      logic [3:0]          err_unit;
      logic                unit_mismatch;
   } fault_evt_s;
endpackage
`default_nettype wire

// ---- rtl/io_error_status_words.sv ----
// ahb-lite read-only bank of i/o configuration and bus-unit error words
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - over five motion modules sets bit 10
// - table model mismatch sets bit 11
// - duplicate processor unit numbers set bit 13
// - special unit duplicate or number 0-9 dup
// - overlapping basic unit words set bit 13
// - excess fault: cause 15:13, detail 12:0
// - too many points stores point total
// - over 32 interrupt inputs stores count
// - too many racks stores rack count
// - bus error slot in bits 7:0
// - bus error rack in bits 15:8
// - missing end cover loads 0E both
// - unknown location loads 0F both
// - memory error sets bit 15, table flag if in table
// - settings memory fault sets flag plus 15
// - processor duplicate sets per-unit map bit
// - exchange fault sets bit 7, map bit
// - installed unit mismatch sets bit 3
// - internal unit fault also sets bit 7
module io_error_status_words
   import io_err_pkg::*;
#(
   parameter int MM_MAX        = 5,       // motion modules allowed
   parameter int IO_POINTS_MAX = 640,     // coordinator point limit
   parameter int IRQ_MAX       = 32,      // interrupt inputs allowed
   parameter int RACK_MAX      = 1        // expansion racks allowed
) (
   // clock and reset
   input  wire logic                   hclk,
   input  wire logic                   hresetn,
   // ahb-lite slave
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic                        hreadyout,
   output logic                        hresp,
   output logic [31:0]                 hrdata,
   // detection logic
   input  wire io_err_pkg::cfg_check_s cfg,
   input  wire io_err_pkg::fault_evt_s evt
);
   import io_err_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // status words, each a flip-flop bank cleared only by reset
   logic [15:0] io_flags_q;       // io_error_flags_word
   logic [15:0] unit_flags_q;     // unit_error_flags_word
   logic [15:0] mem_detail_q;     // memory_error_detail_word
   logic [15:0] bus_loc_q;        // bus_error_location_word
   logic [15:0] excess_q;         // excess_io_detail_word
   logic [15:0] dup_map_q;        // proc_unit_duplicate_map
   logic [15:0] err_map_q;        // proc_unit_error_map
   logic [15:0] excess_d;         // next excess word
   logic        excess_hit;       // a size check failed
   logic        sio_dup_hit;      // special unit numbering fault
   logic [15:0] dup_onehot;       // processor unit being duplicated
   logic [15:0] err_onehot;       // processor unit in error
   logic        rd_take;          // read address phase accepted
   logic        wr_take;          // write address phase accepted
   logic [31:0] rdata_d;          // word selected for the data phase

   ////////////////////////////////////////////////////////////////////////
   // decoded event terms
   assign sio_dup_hit = evt.sio_stb &&
                        (evt.sio_dup || evt.sio_unit <= SIO_LOW_LAST);
   assign dup_onehot  = evt.cpu_dup_stb ?
                        (16'h0001 << evt.cpu_dup_unit) : 16'h0000;
   assign err_onehot  = (evt.xchg_err_stb || evt.unit_fault_stb) ?
                        (16'h0001 << evt.err_unit) : 16'h0000;

   ////////////////////////////////////////////////////////////////////////
   // configuration, duplication and memory flags; bits only ever rise
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         io_flags_q <= WORD_RESET;
      end else begin
         // a level check: sets the flag in any cycle the count is high; it stays set until reset
         if (32'(cfg.mm_count) > MM_MAX) begin
            io_flags_q[BIT_IO_SETTING] <= 1'b1;
         end
         if (evt.model_mismatch) begin
            io_flags_q[BIT_MODEL_MISM] <= 1'b1;
         end
         // three independent causes share one duplication bit
         if (evt.cpu_dup_stb || sio_dup_hit || evt.basic_overlap) begin
            io_flags_q[BIT_DUPLICATE] <= 1'b1;
         end
         if (evt.mem_err_stb) begin
            io_flags_q[BIT_MEMORY] <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // memory fault location
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mem_detail_q <= WORD_RESET;
      end else if (evt.mem_err_stb) begin
         if (evt.mem_in_table) begin
            mem_detail_q[BIT_MEM_TABLE] <= 1'b1;
         end
         if (evt.mem_in_settings) begin
            mem_detail_q[BIT_MEM_SETTINGS] <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // excess i/o cause and detail; points win over interrupts over racks
   always_comb begin
      excess_hit = 1'b1;
      excess_d   = excess_q;
      if (32'(cfg.io_points) > IO_POINTS_MAX) begin
         excess_d = {CAUSE_IO_POINTS, cfg.io_points};
      end else if (32'(cfg.irq_inputs) > IRQ_MAX) begin
         excess_d = {CAUSE_IRQ, cfg.irq_inputs};
      end else if (32'(cfg.racks) > RACK_MAX) begin
         excess_d = {CAUSE_RACKS, cfg.racks};
      end else begin
         excess_hit = 1'b0;
      end
   end

   // the last failing check is kept; a passing check leaves it alone
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         excess_q <= WORD_RESET;
      end else if (cfg.cfg_stb && excess_hit) begin
         excess_q <= excess_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // i/o bus error location, rack high byte and slot low byte
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_loc_q <= WORD_RESET;
      end else if (evt.bus_err_stb) begin
         case (evt.bus_err_kind)
            BUS_LOC_KNOWN: begin
               bus_loc_q <= {evt.bus_rack, evt.bus_slot};
            end
            BUS_NO_COVER: begin
               bus_loc_q <= {LOC_NO_COVER, LOC_NO_COVER};
            end
            default: begin
               // undefined kinds are treated as an unknown location
               bus_loc_q <= {LOC_UNKNOWN, LOC_UNKNOWN};
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // processor bus unit flags and per-unit maps
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         unit_flags_q <= WORD_RESET;
      end else begin
         if (evt.unit_mismatch) begin
            unit_flags_q[BIT_UNIT_SETTING] <= 1'b1;
         end
         // exchange path and unit-internal faults report alike
         if (evt.xchg_err_stb || evt.unit_fault_stb) begin
            unit_flags_q[BIT_UNIT_ERROR] <= 1'b1;
         end
      end
   end

   // maps accumulate; several units may be flagged at once
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dup_map_q <= WORD_RESET;
         err_map_q <= WORD_RESET;
      end else begin
         dup_map_q <= dup_map_q | dup_onehot;
         err_map_q <= err_map_q | err_onehot;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // ahb-lite slave: zero wait states, read data caught at address phase
   assign rd_take = hsel && hready && htrans[1] && !hwrite;
   assign wr_take = hsel && hready && htrans[1] && hwrite;

   // unmapped offsets read as zero, upper half always zero
   always_comb begin
      rdata_d = 32'h0000_0000;
      case (haddr[ADDR_W-1:0])
         OFF_IO_FLAGS:   rdata_d = {16'h0000, io_flags_q};
         OFF_UNIT_FLAGS: rdata_d = {16'h0000, unit_flags_q};
         OFF_MEM_DETAIL: rdata_d = {16'h0000, mem_detail_q};
         OFF_BUS_LOC:    rdata_d = {16'h0000, bus_loc_q};
         OFF_EXCESS:     rdata_d = {16'h0000, excess_q};
         OFF_DUP_MAP:    rdata_d = {16'h0000, dup_map_q};
         OFF_ERR_MAP:    rdata_d = {16'h0000, err_map_q};
         default:        rdata_d = 32'h0000_0000;
      endcase
      if (haddr[31:ADDR_W] != '0) begin
         rdata_d = 32'h0000_0000;
      end
   end

   // hrdata only moves on an accepted read, so it stands until the next
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_take) begin
         hrdata <= rdata_d;
      end
   end

   // never stalls, never errors; writes are accepted and dropped
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= HRESP_OKAY;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_mm_count;
      @(posedge hclk) disable iff (!hresetn)
      (32'(cfg.mm_count) > MM_MAX) |=> io_flags_q[BIT_IO_SETTING];
   endproperty
   a_mm_count: assert property (p_mm_count)
      else $error("motion module excess not flagged");

   property p_model;
      @(posedge hclk) disable iff (!hresetn)
      evt.model_mismatch |=> io_flags_q[BIT_MODEL_MISM] [*3];
   endproperty
   a_model: assert property (p_model)
      else $error("model mismatch flag missing or dropped");

   property p_cpu_dup;
      @(posedge hclk) disable iff (!hresetn)
      evt.cpu_dup_stb |=> io_flags_q[BIT_DUPLICATE] &&
                          dup_map_q[$past(evt.cpu_dup_unit)];
   endproperty
   a_cpu_dup: assert property (p_cpu_dup)
      else $error("processor duplicate not flagged in both words");

   property p_sio_low;
      @(posedge hclk) disable iff (!hresetn)
      (evt.sio_stb && evt.sio_unit <= SIO_LOW_LAST) ##1 1'b1
         |-> io_flags_q[BIT_DUPLICATE];
   endproperty
   a_sio_low: assert property (p_sio_low)
      else $error("special unit low number not flagged");

   property p_basic;
      @(posedge hclk) disable iff (!hresetn)
      evt.basic_overlap |-> ##1 io_flags_q[BIT_DUPLICATE];
   endproperty
   a_basic: assert property (p_basic)
      else $error("basic unit overlap not flagged");

   property p_points;
      @(posedge hclk) disable iff (!hresetn)
      (cfg.cfg_stb && 32'(cfg.io_points) > IO_POINTS_MAX)
         |=> excess_q == {CAUSE_IO_POINTS, $past(cfg.io_points)};
   endproperty
   a_points: assert property (p_points)
      else $error("point total not stored");

   property p_irq;
      @(posedge hclk) disable iff (!hresetn)
      (cfg.cfg_stb && 32'(cfg.io_points) <= IO_POINTS_MAX &&
       32'(cfg.irq_inputs) > IRQ_MAX)
         |=> excess_q[15:13] == CAUSE_IRQ &&
             excess_q[12:0] == $past(cfg.irq_inputs);
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt input count not stored");

   property p_racks;
      @(posedge hclk) disable iff (!hresetn)
      (cfg.cfg_stb && 32'(cfg.io_points) <= IO_POINTS_MAX &&
       32'(cfg.irq_inputs) <= IRQ_MAX && 32'(cfg.racks) > RACK_MAX)
         |=> excess_q == {CAUSE_RACKS, $past(cfg.racks)};
   endproperty
   a_racks: assert property (p_racks)
      else $error("rack count not stored");

   property p_bus_loc;
      @(posedge hclk) disable iff (!hresetn)
      (evt.bus_err_stb && evt.bus_err_kind == BUS_LOC_KNOWN)
         |=> bus_loc_q[7:0] == $past(evt.bus_slot) &&
             bus_loc_q[15:8] == $past(evt.bus_rack);
   endproperty
   a_bus_loc: assert property (p_bus_loc)
      else $error("bus error location wrong");

   property p_no_cover;
      @(posedge hclk) disable iff (!hresetn)
      (evt.bus_err_stb && evt.bus_err_kind == BUS_NO_COVER)
         |=> bus_loc_q == {LOC_NO_COVER, LOC_NO_COVER};
   endproperty
   a_no_cover: assert property (p_no_cover)
      else $error("missing end cover code wrong");

   property p_unknown;
      @(posedge hclk) disable iff (!hresetn)
      (evt.bus_err_stb && evt.bus_err_kind == BUS_LOC_UNSURE)
         |=> bus_loc_q == {LOC_UNKNOWN, LOC_UNKNOWN};
   endproperty
   a_unknown: assert property (p_unknown)
      else $error("unknown location code wrong");

   property p_mem_table;
      @(posedge hclk) disable iff (!hresetn)
      (evt.mem_err_stb && evt.mem_in_table)
         |=> io_flags_q[BIT_MEMORY] && mem_detail_q[BIT_MEM_TABLE];
   endproperty
   a_mem_table: assert property (p_mem_table)
      else $error("table memory fault not flagged");

   property p_mem_set;
      @(posedge hclk) disable iff (!hresetn)
      (evt.mem_err_stb && evt.mem_in_settings)
         |=> io_flags_q[BIT_MEMORY] && mem_detail_q[BIT_MEM_SETTINGS];
   endproperty
   a_mem_set: assert property (p_mem_set)
      else $error("settings memory fault not flagged");

   property p_dup_map_src;
      @(posedge hclk) disable iff (!hresetn)
      $rose(dup_map_q[0]) |-> $past(evt.cpu_dup_stb) &&
                              $past(evt.cpu_dup_unit) == 4'h0;
   endproperty
   a_dup_map_src: assert property (p_dup_map_src)
      else $error("duplicate map bit set without cause");

   property p_xchg;
      @(posedge hclk) disable iff (!hresetn)
      evt.xchg_err_stb |=> unit_flags_q[BIT_UNIT_ERROR] &&
                           err_map_q[$past(evt.err_unit)];
   endproperty
   a_xchg: assert property (p_xchg)
      else $error("exchange fault not flagged");

   property p_unit_set;
      @(posedge hclk) disable iff (!hresetn)
      evt.unit_mismatch |=> unit_flags_q[BIT_UNIT_SETTING];
   endproperty
   a_unit_set: assert property (p_unit_set)
      else $error("unit setting mismatch not flagged");

   property p_unit_fault;
      @(posedge hclk) disable iff (!hresetn)
      evt.unit_fault_stb |=> unit_flags_q[BIT_UNIT_ERROR];
   endproperty
   a_unit_fault: assert property (p_unit_fault)
      else $error("internal unit fault not flagged");

   property p_read_only;
      @(posedge hclk) disable iff (!hresetn)
      (wr_take && !evt.cpu_dup_stb && !evt.xchg_err_stb &&
       !evt.unit_fault_stb)
         |=> $stable(dup_map_q) && $stable(err_map_q);
   endproperty
   a_read_only: assert property (p_read_only)
      else $error("write altered a status word");

   property p_read_data;
      @(posedge hclk) disable iff (!hresetn)
      (rd_take && haddr == 32'(OFF_IO_FLAGS))
         |=> hrdata == {16'h0000, $past(io_flags_q)} && hreadyout;
   endproperty
   a_read_data: assert property (p_read_data)
      else $error("read of flag word returned wrong data");

endmodule
`default_nettype wire
